// ### rtl/rlc_pkg.sv
// Purpose: Shared constants and types for the remote link connect monitor
// Assumes: 50 MHz aclk, AXI4-Lite register access with 12-bit addresses
// Notes:   Offsets below 0x800 are local registers, the upper half is remote
package rlc_pkg;
    // Register offsets and the remote window
    localparam logic [11:0] OFS_STATUS    = 12'h000;
    localparam logic [11:0] OFS_INT_STAT  = 12'h004;
    localparam logic [11:0] OFS_INT_MASK  = 12'h008;
    localparam logic [11:0] OFS_CTRL      = 12'h00c;
    localparam logic [11:0] OFS_POLL_DATA = 12'h010;
    localparam int          RMT_BIT       = 11;
    localparam logic [10:0] POLL_ADDR     = 11'h000;

    // Status bit positions
    localparam int ST_CABLE  = 0;
    localparam int ST_POWER  = 1;
    localparam int ST_LINK   = 2;
    localparam int ST_ONLINE = 3;
    localparam int ST_W      = 4;

    // Interrupt bit positions, shared by status and mask
    localparam int IB_ATTACH    = 0;
    localparam int IB_DETACH    = 1;
    localparam int IB_PWR_UP    = 2;
    localparam int IB_PWR_DOWN  = 3;
    localparam int IB_LINK_LOST = 4;
    localparam int IB_REMOTE    = 5;
    localparam int INT_W        = 6;

    // Control bits and reset values
    localparam int                 CT_POLL_EN = 0;
    localparam logic               CTRL_RST   = 1'b1;
    localparam logic [INT_W-1:0]   MASK_RST   = 6'h00;

    // AXI response codes
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    localparam logic [1:0] RESP_DECERR = 2'b11;

    // Timing
    localparam int CLK_NS    = 20;
    localparam int POLL_NS   = 8000;
    localparam int POLL_CYC  = POLL_NS / CLK_NS;
    localparam int FILTER_MS = 100;
    localparam int FILTER_CYC = FILTER_MS * 1000000 / CLK_NS;

    // Remote bus request and response
    typedef struct packed {
        logic        poll;
        logic        we;
        logic [10:0] addr;
        logic [3:0]  strb;
        logic [31:0] wdata;
    } rlc_rmt_req_t;

    typedef struct packed {
        logic        ack;
        logic        err;
        logic [31:0] rdata;
    } rlc_rmt_rsp_t;

    typedef enum logic {RM_IDLE, RM_WAIT} rlc_rm_state_t;
endpackage

// ### rtl/rlc_filter.sv
// Purpose: Activation time filter for one synchronised detect level
// Assumes: raw is already in the aclk domain
// Notes:   Rising needs LIMIT steady cycles, falling passes at once
`timescale 1ns/1ps
module rlc_filter #(
    parameter int unsigned LIMIT = 5000000
) (
    input  wire logic aclk,    // System clock
    input  wire logic aresetn, // Synchronous reset, active low
    input  wire logic raw,     // Synchronised detect level
    output logic      qual     // Qualified detect level
);
    localparam int CNT_W = $clog2(LIMIT + 1);

    logic [CNT_W-1:0] cnt_ff;
    logic             done_ff;

    // Drop passes straight through the gate
    assign qual = raw & done_ff;

    // Count steady high cycles, restart on any drop
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_ff  <= '0;
            done_ff <= 1'b0;
        end else if (!raw) begin
            cnt_ff  <= '0;
            done_ff <= 1'b0;
        end else if (!done_ff) begin
            if (cnt_ff == CNT_W'(LIMIT - 1)) begin
                done_ff <= 1'b1;
            end else begin
                cnt_ff <= cnt_ff + 1'b1;
            end
        end
    end

    a_filter_min: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(qual) |-> $past(cnt_ff) == CNT_W'(LIMIT - 1) && $past(raw))
        else $error("Detect qualified before the filter time");

    a_drop_fast: assert property (@(posedge aclk) disable iff (!aresetn)
        $fell(raw) |-> !qual)
        else $error("Detect not dropped in the cycle of the fall");

    a_restart_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        !raw |=> cnt_ff == '0 && !done_ff)
        else $error("Filter count not restarted after a drop");
endmodule // rlc_filter

// ### rtl/rlc_monitor.sv
// Purpose: Qualify docking attachment and bridge the remote bus window
// Assumes: Detect pins are asynchronous; remote bus logic runs on aclk
// Notes:   Offsets from 0x800 up are forwarded to the remote unit
// Operation
// - Remote window forwarded to remote unit
// - Status shows cable attached and unit powered
// - Status shows link signal valid
// - Poll every 8 us refreshes interrupt status
// - Cable detect holds even when unpowered
// - Qualify detect after 100 ms steady
// - Drop qualified detect immediately
//
// Design decisions made here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
module rlc_monitor
    import rlc_pkg::*;
#(
    parameter int unsigned FILTER_LIMIT = rlc_pkg::FILTER_CYC
) (
    input  wire logic                  aclk,           // System clock
    input  wire logic                  aresetn,        // Synchronous reset, active low
    input  wire logic [11:0]           s_awaddr,       // Write address
    input  wire logic                  s_awvalid,      // Write address valid
    output logic                       s_awready,      // Write address ready
    input  wire logic [31:0]           s_wdata,        // Write data
    input  wire logic [3:0]            s_wstrb,        // Write byte strobes
    input  wire logic                  s_wvalid,       // Write data valid
    output logic                       s_wready,       // Write data ready
    output logic [1:0]                 s_bresp,        // Write response
    output logic                       s_bvalid,       // Write response valid
    input  wire logic                  s_bready,       // Write response ready
    input  wire logic [11:0]           s_araddr,       // Read address
    input  wire logic                  s_arvalid,      // Read address valid
    output logic                       s_arready,      // Read address ready
    output logic [31:0]                s_rdata,        // Read data
    output logic [1:0]                 s_rresp,        // Read response
    output logic                       s_rvalid,       // Read data valid
    input  wire logic                  s_rready,       // Read data ready
    input  wire logic                  cable_det_pin,  // Raw cable detect
    input  wire logic                  opto_sense_pin, // Raw opto loop sense
    input  wire logic                  link_sig_pin,   // Raw link signal valid
    output logic                       rmt_valid,      // Remote request valid
    output rlc_pkg::rlc_rmt_req_t      rmt_req,        // Remote request payload
    input  wire rlc_pkg::rlc_rmt_rsp_t rmt_rsp,        // Remote response
    output logic                       irq             // Interrupt, active high
);
    import rlc_pkg::*;
    localparam logic [8:0] POLL_LAST = 9'(POLL_CYC - 1);

    function automatic logic is_remote(input logic [11:0] addr);
        return addr[RMT_BIT];
    endfunction

    logic [2:0]         pin_s1_ff, pin_s2_ff;
    logic               cable_q, opto_q, link_v, link_ok, poll_run;
    logic [ST_W-1:0]    stat_ff;
    logic [INT_W-1:0]   int_stat_ff, int_mask_ff, ev, int_clr;
    logic               ctrl_en_ff, irq_ff;
    logic [8:0]         poll_cnt_ff;
    logic               poll_pend_ff, poll_fire;
    logic [31:0]        poll_data_ff;
    rlc_rm_state_t      rm_state_ff, nxt_rm_state;
    logic               rmt_valid_ff;
    rlc_rmt_req_t       rmt_req_ff, nxt_rmt_req;
    logic               idle, pick_poll, pick_wr, pick_rd, launch, rm_fin;
    logic               wr_rmt_fin, rd_rmt_fin, poll_ok;
    logic [1:0]         rmt_resp;
    logic               aw_ok_ff, w_ok_ff, awready_ff, wready_ff, bvalid_ff;
    logic [11:0]        awaddr_ff, araddr_ff;
    logic [31:0]        wdata_ff, rdata_ff, loc_rdata;
    logic [3:0]         wstrb_ff;
    logic [1:0]         bresp_ff, rresp_ff, loc_wresp, loc_rresp;
    logic               wr_rmt_ff, wr_go, wr_loc, wr_fin, nxt_aw_ok, nxt_w_ok;
    logic               ar_ok_ff, arready_ff, rvalid_ff, rd_rmt_ff;
    logic               rd_go, rd_loc, rd_fin, nxt_ar_ok;

    // Two-flop synchronisers for the detect pins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_s1_ff <= 3'h0;
            pin_s2_ff <= 3'h0;
        end else begin
            pin_s1_ff <= {link_sig_pin, opto_sense_pin, cable_det_pin};
            pin_s2_ff <= pin_s1_ff;
        end
    end

    // Cable detect stands alone, valid without remote power
    rlc_filter #(.LIMIT(FILTER_LIMIT)) u_cable_filt (
        .aclk    (aclk),
        .aresetn (aresetn),
        .raw     (pin_s2_ff[0]),
        .qual    (cable_q)
    );

    // Opto loop only carries current from a powered remote unit
    rlc_filter #(.LIMIT(FILTER_LIMIT)) u_opto_filt (
        .aclk    (aclk),
        .aresetn (aresetn),
        .raw     (pin_s2_ff[1]),
        .qual    (opto_q)
    );

    // Connection qualification
    assign link_v   = pin_s2_ff[2];
    assign link_ok  = cable_q & opto_q & link_v;
    assign poll_run = link_ok & ctrl_en_ff;

    // Edge events against last cycle's status, and a nonzero poll answer
    assign ev[IB_ATTACH]    = cable_q & ~stat_ff[ST_CABLE];
    assign ev[IB_DETACH]    = ~cable_q & stat_ff[ST_CABLE];
    assign ev[IB_PWR_UP]    = opto_q & ~stat_ff[ST_POWER];
    assign ev[IB_PWR_DOWN]  = ~opto_q & stat_ff[ST_POWER];
    assign ev[IB_LINK_LOST] = ~link_v & stat_ff[ST_LINK];
    assign ev[IB_REMOTE]    = poll_ok & (rmt_rsp.rdata != 32'h0000_0000);
    assign int_clr = {INT_W{rd_loc && araddr_ff == OFS_INT_STAT}};

    // Status, sticky interrupts and interrupt level; set beats clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stat_ff     <= '0;
            int_stat_ff <= '0;
            irq_ff      <= 1'b0;
        end else begin
            stat_ff     <= {poll_run, link_v, opto_q, cable_q};
            int_stat_ff <= (int_stat_ff & ~int_clr) | ev;
            irq_ff      <= |(int_stat_ff & int_mask_ff);
        end
    end

    // Poll interval counter
    assign poll_fire = poll_run && poll_cnt_ff == POLL_LAST;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            poll_cnt_ff  <= 9'h000;
            poll_pend_ff <= 1'b0;
        end else if (!poll_run) begin
            poll_cnt_ff  <= 9'h000;
            poll_pend_ff <= 1'b0;
        end else begin
            poll_cnt_ff  <= poll_fire ? 9'h000 : poll_cnt_ff + 9'h001;
            poll_pend_ff <= poll_fire | (poll_pend_ff & ~pick_poll);
        end
    end

    // Remote bus arbitration: poll first, then write, then read
    assign idle       = rm_state_ff == RM_IDLE;
    assign pick_poll  = idle & poll_pend_ff & poll_run;
    assign pick_wr    = idle & ~poll_pend_ff & wr_rmt_ff;
    assign pick_rd    = idle & ~poll_pend_ff & ~wr_rmt_ff & rd_rmt_ff;
    assign launch     = pick_poll | ((pick_wr | pick_rd) & link_ok);
    assign rm_fin     = ~idle & (rmt_rsp.ack | ~link_ok);
    assign wr_rmt_fin = (rm_fin & rmt_req_ff.we) | (pick_wr & ~link_ok);
    assign rd_rmt_fin = (rm_fin & ~rmt_req_ff.we & ~rmt_req_ff.poll) | (pick_rd & ~link_ok);
    assign poll_ok    = rm_fin & rmt_req_ff.poll & rmt_rsp.ack & link_ok;
    assign rmt_resp   = (~link_ok | rmt_rsp.err) ? RESP_SLVERR : RESP_OKAY;

    // Next remote request and state
    always_comb begin
        nxt_rmt_req  = rmt_req_ff;
        nxt_rm_state = rm_state_ff;
        case (rm_state_ff)
            RM_IDLE: begin
                if (pick_poll) begin
                    nxt_rmt_req  = '{1'b1, 1'b0, POLL_ADDR, 4'h0, 32'h0000_0000};
                    nxt_rm_state = RM_WAIT;
                end else if (launch && pick_wr) begin
                    nxt_rmt_req  = '{1'b0, 1'b1, awaddr_ff[10:0], wstrb_ff, wdata_ff};
                    nxt_rm_state = RM_WAIT;
                end else if (launch) begin
                    nxt_rmt_req  = '{1'b0, 1'b0, araddr_ff[10:0], 4'h0, 32'h0000_0000};
                    nxt_rm_state = RM_WAIT;
                end
            end
            RM_WAIT: begin
                if (rm_fin) begin
                    nxt_rm_state = RM_IDLE;
                end
            end
            default: nxt_rm_state = RM_IDLE;
        endcase
    end

    // Remote request registers, valid held until acknowledged or link lost
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rm_state_ff  <= RM_IDLE;
            rmt_req_ff   <= '0;
            rmt_valid_ff <= 1'b0;
            poll_data_ff <= 32'h0000_0000;
        end else begin
            rm_state_ff  <= nxt_rm_state;
            rmt_req_ff   <= nxt_rmt_req;
            rmt_valid_ff <= nxt_rm_state == RM_WAIT;
            if (poll_ok) begin
                poll_data_ff <= rmt_rsp.rdata;
            end
        end
    end

    // Write channel decode
    assign wr_go     = aw_ok_ff & w_ok_ff & ~bvalid_ff & ~wr_rmt_ff;
    assign wr_loc    = wr_go & ~is_remote(awaddr_ff);
    assign wr_fin    = wr_loc | wr_rmt_fin;
    assign nxt_aw_ok = (s_awvalid & awready_ff) | (aw_ok_ff & ~wr_fin);
    assign nxt_w_ok  = (s_wvalid & wready_ff) | (w_ok_ff & ~wr_fin);
    assign loc_wresp = (awaddr_ff[11:5] == 7'h00 && awaddr_ff[1:0] == 2'b00
                        && awaddr_ff[4:2] <= 3'h4) ? RESP_OKAY : RESP_DECERR;

    // Write address and data capture, in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_ok_ff   <= 1'b0;
            w_ok_ff    <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff  <= 1'b0;
            awaddr_ff  <= 12'h000;
            wdata_ff   <= 32'h0000_0000;
            wstrb_ff   <= 4'h0;
        end else begin
            aw_ok_ff   <= nxt_aw_ok;
            w_ok_ff    <= nxt_w_ok;
            awready_ff <= ~nxt_aw_ok;
            wready_ff  <= ~nxt_w_ok;
            if (s_awvalid && awready_ff) begin
                awaddr_ff <= s_awaddr;
            end
            if (s_wvalid && wready_ff) begin
                wdata_ff <= s_wdata;
                wstrb_ff <= s_wstrb;
            end
        end
    end

    // Write response, local register writes and remote handoff
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff   <= 1'b0;
            bresp_ff    <= RESP_OKAY;
            wr_rmt_ff   <= 1'b0;
            int_mask_ff <= MASK_RST;
            ctrl_en_ff  <= CTRL_RST;
        end else begin
            if (wr_go && is_remote(awaddr_ff)) begin
                wr_rmt_ff <= 1'b1;
            end else if (wr_rmt_fin) begin
                wr_rmt_ff <= 1'b0;
            end
            if (wr_fin) begin
                bvalid_ff <= 1'b1;
                bresp_ff  <= wr_loc ? loc_wresp : rmt_resp;
            end else if (s_bready) begin
                bvalid_ff <= 1'b0;
            end
            if (wr_loc && wstrb_ff[0] && awaddr_ff == OFS_INT_MASK) begin
                int_mask_ff <= wdata_ff[INT_W-1:0];
            end
            if (wr_loc && wstrb_ff[0] && awaddr_ff == OFS_CTRL) begin
                ctrl_en_ff <= wdata_ff[CT_POLL_EN];
            end
        end
    end

    // Read channel decode and local register mux
    assign rd_go     = ar_ok_ff & ~rvalid_ff & ~rd_rmt_ff;
    assign rd_loc    = rd_go & ~is_remote(araddr_ff);
    assign rd_fin    = rd_loc | rd_rmt_fin;
    assign nxt_ar_ok = (s_arvalid & arready_ff) | (ar_ok_ff & ~rd_fin);
    assign loc_rdata = (araddr_ff == OFS_STATUS)    ? 32'(stat_ff) :
                       (araddr_ff == OFS_INT_STAT)  ? 32'(int_stat_ff) :
                       (araddr_ff == OFS_INT_MASK)  ? 32'(int_mask_ff) :
                       (araddr_ff == OFS_CTRL)      ? 32'(ctrl_en_ff) :
                       (araddr_ff == OFS_POLL_DATA) ? poll_data_ff : 32'h0000_0000;
    assign loc_rresp = (araddr_ff[11:5] == 7'h00 && araddr_ff[1:0] == 2'b00
                        && araddr_ff[4:2] <= 3'h4) ? RESP_OKAY : RESP_DECERR;

    // Read address capture, read data and remote handoff
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ar_ok_ff   <= 1'b0;
            arready_ff <= 1'b0;
            araddr_ff  <= 12'h000;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= 32'h0000_0000;
            rresp_ff   <= RESP_OKAY;
            rd_rmt_ff  <= 1'b0;
        end else begin
            ar_ok_ff   <= nxt_ar_ok;
            arready_ff <= ~nxt_ar_ok;
            if (s_arvalid && arready_ff) begin
                araddr_ff <= s_araddr;
            end
            if (rd_go && is_remote(araddr_ff)) begin
                rd_rmt_ff <= 1'b1;
            end else if (rd_rmt_fin) begin
                rd_rmt_ff <= 1'b0;
            end
            if (rd_fin) begin
                rvalid_ff <= 1'b1;
                rdata_ff  <= rd_loc ? loc_rdata : (link_ok ? rmt_rsp.rdata : 32'h0000_0000);
                rresp_ff  <= rd_loc ? loc_rresp : rmt_resp;
            end else if (s_rready) begin
                rvalid_ff <= 1'b0;
            end
        end
    end

    // Outputs straight from flip-flops
    assign s_awready = awready_ff;
    assign s_wready  = wready_ff;
    assign s_bvalid  = bvalid_ff;
    assign s_bresp   = bresp_ff;
    assign s_arready = arready_ff;
    assign s_rvalid  = rvalid_ff;
    assign s_rdata   = rdata_ff;
    assign s_rresp   = rresp_ff;
    assign rmt_valid = rmt_valid_ff;
    assign rmt_req   = rmt_req_ff;
    assign irq       = irq_ff;

    a_remote_fwd: assert property (@(posedge aclk) disable iff (!aresetn)
        pick_wr && link_ok |=> rmt_valid && rmt_req.we
            && rmt_req.addr == $past(awaddr_ff[10:0]))
        else $error("Remote write not forwarded");

    a_status_conn: assert property (@(posedge aclk) disable iff (!aresetn)
        ##1 stat_ff[ST_CABLE] == $past(cable_q) && stat_ff[ST_POWER] == $past(opto_q))
        else $error("Connect or power status wrong");

    a_status_link: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(link_v) |=> stat_ff[ST_LINK])
        else $error("Link status not shown");

    a_poll_period: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(poll_pend_ff) |-> $past(poll_cnt_ff) == POLL_LAST && $past(poll_run))
        else $error("Poll raised off the interval");

    a_poll_gate: assert property (@(posedge aclk) disable iff (!aresetn)
        !poll_run |=> !poll_pend_ff && poll_cnt_ff == 9'h000
            && !(rmt_valid && rmt_req.poll && !$past(rmt_valid)))
        else $error("Polling continued without a valid connection");

    a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
        ##1 irq == |($past(int_stat_ff) & $past(int_mask_ff)))
        else $error("Interrupt level does not follow masked status");
endmodule // rlc_monitor

// ### tb/rlc_remote_model.sv
// Purpose: Remote unit model answering the remote bus
// Assumes: One aclk domain, ack is a one-cycle pulse
// Notes:   Slow mode stretches each answer by six cycles
`timescale 1ns/1ps
module rlc_remote_model (
    input  wire logic                  aclk,       // System clock
    input  wire logic                  aresetn,    // Reset, active low
    input  wire logic                  rmt_valid,  // Request valid
    input  wire rlc_pkg::rlc_rmt_req_t rmt_req,    // Request payload
    output rlc_pkg::rlc_rmt_rsp_t      rmt_rsp,    // Response
    input  wire logic                  powered,    // Unit has power
    input  wire logic                  attached,   // Cable in place
    input  wire logic                  slow,       // Stretch the answer
    input  wire logic [31:0]           poll_word,  // Poll answer
    output logic                       opto_sense  // Loop current sensed
);
    import rlc_pkg::*;
    logic [31:0] mem [0:2047];
    logic [2:0]  wait_cnt;
    // Loop current flows only while powered and attached
    assign opto_sense = powered & attached;
    // Answer each request once after the wait; idle data lines toggle
    always @(posedge aclk) begin
        if (!aresetn) begin
            wait_cnt <= 3'h0;
            rmt_rsp  <= '0;
        end else if (rmt_valid && !rmt_rsp.ack && wait_cnt >= (slow ? 3'h6 : 3'h0)) begin
            wait_cnt <= 3'h0;
            rmt_rsp  <= {1'b1, 1'b0, rmt_req.poll ? poll_word : mem[rmt_req.addr]};
            if (rmt_req.we) begin
                mem[rmt_req.addr] <= rmt_req.wdata;
            end
        end else begin
            wait_cnt <= (rmt_valid && !rmt_rsp.ack) ? wait_cnt + 3'h1 : 3'h0;
            rmt_rsp  <= {2'b00, ~rmt_rsp.rdata};
        end
    end
endmodule // rlc_remote_model

// ### tb/rlc_monitor_tb.sv
// Purpose: Self-checking bench for the remote link connect monitor
// Assumes: Short filter limit, remote unit model on the far side
// Notes:   Expected values come from bench state and a word table
`timescale 1ns/1ps
module rlc_monitor_tb;
    import rlc_pkg::*;
    localparam int unsigned FLT = 20;
    logic         aclk, aresetn, cab, pwr, lnk, slow, prev_v;
    logic         awvalid, wvalid, bready, arvalid, rready;
    logic [11:0]  awaddr, araddr;
    logic [31:0]  wdata, poll_word;
    logic         awready, wready, bvalid, arready, rvalid, rmt_valid, irq, opto;
    logic [1:0]   bresp, rresp;
    logic [31:0]  rdata;
    rlc_rmt_req_t rmt_req;
    rlc_rmt_rsp_t rmt_rsp;
    logic [31:0]  ref_mem [int];
    int           err_total = 0, checks = 0, polls = 0, gap = 0, gap_last = 0;

    rlc_monitor #(.FILTER_LIMIT(FLT)) u_rlc_monitor (
        .aclk(aclk), .aresetn(aresetn), .s_awaddr(awaddr), .s_awvalid(awvalid),
        .s_awready(awready), .s_wdata(wdata), .s_wstrb(4'hf), .s_wvalid(wvalid),
        .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
        .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata),
        .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready), .cable_det_pin(cab),
        .opto_sense_pin(opto), .link_sig_pin(lnk), .rmt_valid(rmt_valid),
        .rmt_req(rmt_req), .rmt_rsp(rmt_rsp), .irq(irq));
    rlc_remote_model u_rlc_remote_model (
        .aclk(aclk), .aresetn(aresetn), .rmt_valid(rmt_valid), .rmt_req(rmt_req),
        .rmt_rsp(rmt_rsp), .powered(pwr), .attached(cab), .slow(slow),
        .poll_word(poll_word), .opto_sense(opto));

    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    // Poll launches and their spacing
    always @(posedge aclk) begin
        prev_v <= rmt_valid;
        gap    <= gap + 1;
        if (rmt_valid && !prev_v && rmt_req.poll) begin
            polls    <= polls + 1;
            gap_last <= gap;
            gap      <= 1;
        end
    end

    task automatic complete_run();
        if (err_total == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: data %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: resp %b expected %b", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask
    // Address and data offered together, each released when taken
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_ok, w_ok;
        {aw_ok, w_ok} = 2'b00;
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (awready && !aw_ok) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (wready && !w_ok) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b1;
        do @(posedge aclk); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr  <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        rready  <= 1'b1;
        do @(posedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0]  r;
        axi_rd(a, d, r);
        chk_data(d, e);
        chk_resp(r, er);
    endtask
    // Wait for a poll launch, then let its answer land
    task automatic next_poll();
        int p;
        p = polls;
        while (polls == p) @(posedge aclk);
        cyc(12);
    endtask
    // Status word from the pin levels driven so far
    function automatic logic [31:0] st_exp();
        return {28'h0, cab & pwr & lnk, lnk, pwr & cab, cab};
    endfunction

    initial begin : main
        logic [31:0] d, pw;
        logic [1:0]  r;
        int          idx;
        {aresetn, awvalid, wvalid, bready, arvalid, rready, cab, pwr, lnk, slow} = '0;
        {awaddr, araddr, wdata, poll_word} = '0;
        void'($urandom(32'had0e313a));
        cyc(5);
        aresetn <= 1'b1;
        cyc(2);
        rd_chk(OFS_STATUS, 32'h0, RESP_OKAY);
        rd_chk(OFS_INT_MASK, {26'h0, MASK_RST}, RESP_OKAY);
        axi_rd(12'h7fc, d, r);
        chk_resp(r, RESP_DECERR);
        rd_chk(12'h800, 32'h0, RESP_SLVERR);
        // Early drop must restart the filter count
        cab <= 1'b1;
        cyc(15);
        cab <= 1'b0;
        cyc(4);
        cab <= 1'b1;
        cyc(12);
        rd_chk(OFS_STATUS, 32'h0, RESP_OKAY);
        cyc(FLT);
        rd_chk(OFS_STATUS, st_exp(), RESP_OKAY);
        pwr <= 1'b1;
        cyc(FLT + 8);
        rd_chk(OFS_STATUS, st_exp(), RESP_OKAY);
        chk_data(polls, 32'h0);
        lnk <= 1'b1;
        next_poll();
        next_poll();
        chk_data(gap_last, POLL_CYC);
        // Poll enable off stops polling and clears online
        axi_wr(OFS_CTRL, 32'h0, r);
        chk_resp(r, RESP_OKAY);
        idx = polls;
        cyc(900);
        chk_data(polls, idx);
        rd_chk(OFS_STATUS, st_exp() & 32'h7, RESP_OKAY);
        axi_wr(OFS_CTRL, 32'h1, r);
        chk_resp(r, RESP_OKAY);
        rd_chk(OFS_STATUS, st_exp(), RESP_OKAY);
        // Poll result raises, mask gates, read clears
        chk_data({31'h0, irq}, 32'h0);
        pw = $urandom | 32'h1;
        poll_word <= pw;
        axi_wr(OFS_INT_MASK, 32'h1 << IB_REMOTE, r);
        chk_resp(r, RESP_OKAY);
        next_poll();
        chk_data({31'h0, irq}, 32'h1);
        rd_chk(OFS_POLL_DATA, pw, RESP_OKAY);
        poll_word <= 32'h0;
        next_poll();
        axi_rd(OFS_INT_STAT, d, r);
        chk_data(d & (32'h1 << IB_REMOTE), 32'h1 << IB_REMOTE);
        next_poll();
        chk_data({31'h0, irq}, 32'h0);
        // Remote window traffic, prompt and slow answers
        for (int i = 0; i < 6; i++) begin
            idx = $urandom % 512;
            d = $urandom;
            slow <= i[0];
            ref_mem[idx] = d;
            axi_wr(12'h800 | 12'(idx * 4), d, r);
            chk_resp(r, RESP_OKAY);
            rd_chk(12'h800 | 12'(idx * 4), ref_mem[idx], RESP_OKAY);
        end
        lnk <= 1'b0;
        cyc(4);
        rd_chk(OFS_STATUS, st_exp(), RESP_OKAY);
        idx = polls;
        cyc(900);
        chk_data(polls, idx);
        cab <= 1'b0;
        cyc(3);
        rd_chk(OFS_STATUS, 32'h0, RESP_OKAY);
        rd_chk(OFS_INT_STAT, (32'h1 << IB_DETACH) | (32'h1 << IB_PWR_DOWN)
               | (32'h1 << IB_LINK_LOST), RESP_OKAY);
        complete_run();
    end
    initial begin
        #(20 * 30000);
        err_total++;
        complete_run();
    end
endmodule // rlc_monitor_tb
